// File: src/cell_scan_pkg.sv
// Constants, register map and types shared by the cell scan monitor.
package cell_scan_pkg;
    // Timebase: every period and settling value counts whole microseconds.
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS = 1000;
    localparam int CYCLES_PER_TICK = TICK_NS / CLK_PERIOD_NS;

    // Channel layout on the module chain.
    localparam int NUM_CH = 32;
    localparam int CH_W = 5;
    localparam int CNT_W = 8;
    localparam int THERM_W = 3;
    localparam logic [3:0] CELLS_SMALL = 4'hC;
    localparam logic [4:0] CELLS_LARGE = 5'h10;

    // Register byte offsets.
    localparam logic [7:0] ADDR_VARIANT = 8'h00;
    localparam logic [7:0] ADDR_MODCOUNT = 8'h04;
    localparam logic [7:0] ADDR_POWERMODE = 8'h08;
    localparam logic [7:0] ADDR_SCANINT = 8'h0C;
    localparam logic [7:0] ADDR_SETTLE = 8'h10;
    localparam logic [7:0] ADDR_FILTER = 8'h14;
    localparam logic [7:0] ADDR_WDISABLE = 8'h18;
    localparam logic [7:0] ADDR_WINTERVAL = 8'h1C;
    localparam logic [7:0] ADDR_WTHRESH = 8'h20;
    localparam logic [7:0] ADDR_WCEIL = 8'h24;
    localparam logic [7:0] ADDR_RLOW = 8'h28;
    localparam logic [7:0] ADDR_RHIGH = 8'h2C;
    localparam logic [7:0] ADDR_WDLIMIT = 8'h30;
    localparam logic [7:0] ADDR_STATUS = 8'h34;
    localparam logic [7:0] ADDR_FLAGS = 8'h38;

    // Status register fields.
    localparam int ST_FAULT_BIT = 0;
    localparam int ST_ACTIVE_BIT = 1;
    localparam int ST_THERM_LSB = 4;

    // Values after reset.
    localparam logic [31:0] RST_VARIANT = 32'h0000_0000;
    localparam logic [31:0] RST_MODCOUNT = 32'h0000_0001;
    localparam logic [31:0] RST_POWERMODE = 32'h0000_0002;
    localparam logic [31:0] RST_SCANINT = 32'h000F_4240;
    localparam logic [31:0] RST_SETTLE = 32'h0000_C350;
    localparam logic [31:0] RST_FILTER = 32'h0000_0001;
    localparam logic [31:0] RST_WDISABLE = 32'h0000_0000;
    localparam logic [31:0] RST_WINTERVAL = 32'hD693_A400;
    localparam logic [31:0] RST_WTHRESH = 32'h0000_0003;
    localparam logic [31:0] RST_WCEIL = 32'h0000_000A;
    localparam logic [31:0] RST_RLOW = 32'h0000_0320;
    localparam logic [31:0] RST_RHIGH = 32'h0000_03CA;
    localparam logic [31:0] RST_WDLIMIT = 32'h004C_4B40;
    localparam logic [1:0] POWER_MODE_NONE = 2'h2;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_SETTLE = 2'b01,
        SCAN_MEAS = 2'b11,
        SCAN_HOLD = 2'b10
    } scan_state_t;
endpackage

// File: src/us_tick_gen.sv
// Microsecond tick generator dividing the system clock.
`timescale 1ns/1ps
module us_tick_gen (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstN,
    // Tick
    output logic tick
);
    import cell_scan_pkg::*;

    localparam logic [5:0] DIV_LAST = 6'(CYCLES_PER_TICK - 1);

    logic [5:0] div_reg;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            div_reg <= 6'h00;
            tick <= 1'b0;
        end else begin
            tick <= (div_reg == DIV_LAST);
            div_reg <= (div_reg == DIV_LAST) ? 6'h00 : div_reg + 6'h01;
        end
    end
endmodule

// File: src/cell_scan_open_wire_monitor.sv
// Scan scheduler with balancing pause and open-wire detection, Wishbone registers.
//
// Operation
// RULE1: Measure all cells once each scan period.
// RULE2: Thermistors cycle over eight scan periods.
// RULE3: One thermistor per module each scan.
// RULE4: Balancing off during every voltage measurement.
// RULE5: Hold balancing off for settling time first.
// RULE6: Long settling stretches scans; watchdog faults.
// RULE7: One bit picks 7 kHz or 26 Hz.
// RULE8: Software avoids 7 kHz on this variant.
// RULE9: Open-wire detections only with 7 kHz filter.
// RULE10: Wire check at power-up and lockout exit.
// RULE11: Periodic wire check while on DC bus.
// RULE12: Per-channel count sets flag at threshold.
// RULE13: Detection counters saturate at the ceiling.
// RULE14: Software keeps ceiling not below threshold.
// RULE15: Wire check lasts ceiling scan cycles.
// RULE16: Disable bit suppresses all open-wire reporting.
// RULE17: Ratio below lower limit is an error.
// RULE18: Ratio above upper limit is an error.
// RULE19: Software sets module count one or two.
// RULE20: Software sets variant zero or one.
// RULE21: Never power expansion module; mode two.
// RULE22: Periods and settling count in microseconds.
// RULE23: Ratio equal to a limit is fine.
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module cell_scan_open_wire_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    // Module chain link
    output logic measStart,
    input wire logic measDone,
    output logic [cell_scan_pkg::THERM_W-1:0] thermSelect,
    output logic balanceAllow,
    output logic filterSelect,
    output logic wireCheckActive,
    output logic linkPowerSupply,
    output logic [1:0] linkPowerMode,
    input wire logic ratioValid,
    input wire logic [cell_scan_pkg::CH_W-1:0] ratioChannel,
    input wire logic [9:0] ratioValue,
    // System state
    input wire logic lockoutActive,
    input wire logic dcBusConnected,
    output logic scanFault,
    output logic [cell_scan_pkg::NUM_CH-1:0] openWireFlags
);
    import cell_scan_pkg::*;

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wr,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wr[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Equality with a limit is deliberately not an error.
    function automatic logic outOfWindow(input logic [9:0] r, input logic [31:0] lo,
                                         input logic [31:0] hi);
        return ({22'h0, r} < lo) || ({22'h0, r} > hi);
    endfunction

    logic [1:0] rstSync_reg;
    logic rstN;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_reg <= 2'b00;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end
    assign rstN = rstSync_reg[1];

    logic tick;

    us_tick_gen tickGen (
        .clk_sys(clk_sys),
        .rstN(rstN),
        .tick(tick)
    );

    logic [31:0] variant_reg, modCount_reg, powerMode_reg, scanInt_reg, settle_reg;
    logic [31:0] filter_reg, wDisable_reg, wInterval_reg, wThresh_reg, wCeil_reg;
    logic [31:0] rLow_reg, rHigh_reg, wdLimit_reg;
    logic wrEn, faultClear;

    assign wrEn = cyc_i && stb_i && we_i && !ack_o;
    assign faultClear = wrEn && (adr_i == ADDR_STATUS) && sel_i[0] && dat_i[ST_FAULT_BIT];

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            variant_reg <= RST_VARIANT;
            modCount_reg <= RST_MODCOUNT;
            powerMode_reg <= RST_POWERMODE;
            scanInt_reg <= RST_SCANINT;
            settle_reg <= RST_SETTLE;
            filter_reg <= RST_FILTER;
            wDisable_reg <= RST_WDISABLE;
            wInterval_reg <= RST_WINTERVAL;
            wThresh_reg <= RST_WTHRESH;
            wCeil_reg <= RST_WCEIL;
            rLow_reg <= RST_RLOW;
            rHigh_reg <= RST_RHIGH;
            wdLimit_reg <= RST_WDLIMIT;
        end else if (wrEn) begin
            case (adr_i)
                ADDR_VARIANT: variant_reg <= mergeBytes(variant_reg, dat_i, sel_i);
                ADDR_MODCOUNT: modCount_reg <= mergeBytes(modCount_reg, dat_i, sel_i);
                ADDR_POWERMODE: powerMode_reg <= mergeBytes(powerMode_reg, dat_i, sel_i);
                ADDR_SCANINT: scanInt_reg <= mergeBytes(scanInt_reg, dat_i, sel_i);
                ADDR_SETTLE: settle_reg <= mergeBytes(settle_reg, dat_i, sel_i);
                ADDR_FILTER: filter_reg <= mergeBytes(filter_reg, dat_i, sel_i);
                ADDR_WDISABLE: wDisable_reg <= mergeBytes(wDisable_reg, dat_i, sel_i);
                ADDR_WINTERVAL: wInterval_reg <= mergeBytes(wInterval_reg, dat_i, sel_i);
                ADDR_WTHRESH: wThresh_reg <= mergeBytes(wThresh_reg, dat_i, sel_i);
                ADDR_WCEIL: wCeil_reg <= mergeBytes(wCeil_reg, dat_i, sel_i);
                ADDR_RLOW: rLow_reg <= mergeBytes(rLow_reg, dat_i, sel_i);
                ADDR_RHIGH: rHigh_reg <= mergeBytes(rHigh_reg, dat_i, sel_i);
                ADDR_WDLIMIT: wdLimit_reg <= mergeBytes(wdLimit_reg, dat_i, sel_i);
                default: ;
            endcase
        end
    end

    // RULE21: no link power
    assign linkPowerSupply = 1'b0;
    assign linkPowerMode = powerMode_reg[1:0];

    // Scan sequencer.
    scan_state_t state_reg, state_next;
    logic [31:0] scanElapsed_reg, settleCnt_reg, wdCount_reg;
    logic scanBegin, measEnd;

    assign measEnd = (state_reg == SCAN_MEAS) && measDone;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SCAN_IDLE: state_next = SCAN_SETTLE;
            // RULE5: settle before measuring
            SCAN_SETTLE: if (settleCnt_reg >= settle_reg) begin
                state_next = SCAN_MEAS;
            end
            SCAN_MEAS: if (measDone) begin
                state_next = SCAN_HOLD;
            end
            // RULE1: one scan per interval
            SCAN_HOLD: if (scanElapsed_reg >= scanInt_reg) begin
                state_next = SCAN_SETTLE;
            end
            default: state_next = SCAN_IDLE;
        endcase
    end
    assign scanBegin = (state_next == SCAN_SETTLE) && (state_reg != SCAN_SETTLE);

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            state_reg <= SCAN_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // RULE22: microsecond timers
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            scanElapsed_reg <= 32'h0000_0000;
            settleCnt_reg <= 32'h0000_0000;
        end else begin
            if (scanBegin) begin
                scanElapsed_reg <= 32'h0000_0000;
                settleCnt_reg <= 32'h0000_0000;
            end else if (tick) begin
                // RULE6: scan stretches when settling runs long
                if (scanElapsed_reg != 32'hFFFF_FFFF) begin
                    scanElapsed_reg <= scanElapsed_reg + 32'h0000_0001;
                end
                if (state_reg == SCAN_SETTLE) begin
                    settleCnt_reg <= settleCnt_reg + 32'h0000_0001;
                end
            end
        end
    end

    // RULE4: balancing only outside settle and measure
    assign balanceAllow = (state_reg == SCAN_HOLD) || (state_reg == SCAN_IDLE);

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            measStart <= 1'b0;
            thermSelect <= 3'h0;
            filterSelect <= 1'b1;
        end else begin
            measStart <= (state_reg == SCAN_SETTLE) && (state_next == SCAN_MEAS);
            // RULE7: filter select
            filterSelect <= filter_reg[0];
            // RULE2: advance thermistor
            // RULE3: each group steps together
            if (measEnd) begin
                thermSelect <= thermSelect + 3'h1;
            end
        end
    end

    // RULE6: scan-rate watchdog, a new expiry wins over a clear.
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            wdCount_reg <= 32'h0000_0000;
            scanFault <= 1'b0;
        end else begin
            if (measEnd) begin
                wdCount_reg <= 32'h0000_0000;
            end else if (tick && wdCount_reg != 32'hFFFF_FFFF) begin
                wdCount_reg <= wdCount_reg + 32'h0000_0001;
            end
            if (wdCount_reg >= wdLimit_reg) begin
                scanFault <= 1'b1;
            end else if (faultClear) begin
                scanFault <= 1'b0;
            end
        end
    end

    // Open-wire check scheduling.
    logic [31:0] wPeriod_reg;
    logic pending_reg, lockout_reg, periodHit, wireStart;
    logic [CNT_W-1:0] scansLeft_reg;

    assign periodHit = tick && dcBusConnected && !lockoutActive && !wireCheckActive
                       && (wPeriod_reg + 32'h0000_0001 >= wInterval_reg);
    assign wireStart = pending_reg && !wireCheckActive && !lockoutActive && scanBegin;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            // RULE10: power-up check pending
            pending_reg <= 1'b1;
            lockout_reg <= 1'b0;
            wPeriod_reg <= 32'h0000_0000;
        end else begin
            lockout_reg <= lockoutActive;
            // RULE10: lockout exit
            // RULE11: periodic check
            if ((lockout_reg && !lockoutActive) || periodHit) begin
                pending_reg <= 1'b1;
            end else if (wireStart) begin
                pending_reg <= 1'b0;
            end
            if (periodHit || wireCheckActive || !dcBusConnected) begin
                wPeriod_reg <= 32'h0000_0000;
            end else if (tick) begin
                wPeriod_reg <= wPeriod_reg + 32'h0000_0001;
            end
        end
    end

    // RULE15: check spans ceiling scans
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            wireCheckActive <= 1'b0;
            scansLeft_reg <= 8'h00;
        end else if (wireStart) begin
            wireCheckActive <= 1'b1;
            scansLeft_reg <= (wCeil_reg[7:0] == 8'h00) ? 8'h01 : wCeil_reg[7:0];
        end else if (wireCheckActive && measEnd) begin
            scansLeft_reg <= scansLeft_reg - 8'h01;
            if (scansLeft_reg == 8'h01) begin
                wireCheckActive <= 1'b0;
            end
        end
    end

    // Per-channel detection counters and flags.
    logic [CNT_W-1:0] hitCount [0:NUM_CH-1];
    logic [NUM_CH-1:0] flag_reg;
    logic accept, hit;
    logic [4:0] cellsPerModule;

    assign cellsPerModule = variant_reg[0] ? CELLS_LARGE : {1'b0, CELLS_SMALL};
    // RULE9: detections only with the 7 kHz filter
    assign accept = ratioValid && wireCheckActive && !filter_reg[0]
                    && ({31'h0, ratioChannel[4]} < modCount_reg)
                    && ({1'b0, ratioChannel[3:0]} < cellsPerModule);
    // RULE17: below lower
    // RULE18: above upper
    // RULE23: limits inclusive
    assign hit = accept && outOfWindow(ratioValue, rLow_reg, rHigh_reg);

    // Counters restart with each check, so a channel that heals clears on the next one.
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < NUM_CH; i++) begin
                hitCount[i] <= 8'h00;
            end
            flag_reg <= '0;
        end else if (wireStart) begin
            for (int i = 0; i < NUM_CH; i++) begin
                hitCount[i] <= 8'h00;
            end
            flag_reg <= '0;
        end else if (hit) begin
            // RULE13: saturate counter
            if (hitCount[ratioChannel] < wCeil_reg[7:0]) begin
                hitCount[ratioChannel] <= hitCount[ratioChannel] + 8'h01;
            end
            // RULE12: flag at threshold
            if ({24'h0, hitCount[ratioChannel] + 8'h01} >= wThresh_reg) begin
                flag_reg[ratioChannel] <= 1'b1;
            end
        end
    end

    // RULE16: disable suppresses reporting
    assign openWireFlags = wDisable_reg[0] ? '0 : flag_reg;

    // Wishbone answer: one wait state, unmapped reads give zero.
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            case (adr_i)
                ADDR_VARIANT: dat_o <= variant_reg;
                ADDR_MODCOUNT: dat_o <= modCount_reg;
                ADDR_POWERMODE: dat_o <= powerMode_reg;
                ADDR_SCANINT: dat_o <= scanInt_reg;
                ADDR_SETTLE: dat_o <= settle_reg;
                ADDR_FILTER: dat_o <= filter_reg;
                ADDR_WDISABLE: dat_o <= wDisable_reg;
                ADDR_WINTERVAL: dat_o <= wInterval_reg;
                ADDR_WTHRESH: dat_o <= wThresh_reg;
                ADDR_WCEIL: dat_o <= wCeil_reg;
                ADDR_RLOW: dat_o <= rLow_reg;
                ADDR_RHIGH: dat_o <= rHigh_reg;
                ADDR_WDLIMIT: dat_o <= wdLimit_reg;
                ADDR_STATUS: dat_o <= {25'h0, thermSelect, 2'b00, wireCheckActive, scanFault};
                ADDR_FLAGS: dat_o <= openWireFlags;
                default: dat_o <= 32'h0000_0000;
            endcase
        end
    end

    sequence seqSettleToMeas;
        state_reg == SCAN_SETTLE ##1 state_reg == SCAN_MEAS;
    endsequence

    chk_meas_no_balance: assert property (@(posedge clk_sys) disable iff (!rstN) // RULE4
        seqSettleToMeas |-> measStart && !balanceAllow)
        else $error("measurement started with balancing on");

    chk_settle_length: assert property (@(posedge clk_sys) disable iff (!rstN) // RULE5
        seqSettleToMeas |-> $past(settleCnt_reg) >= $past(settle_reg))
        else $error("settling cut short");

    chk_therm_advance: assert property (@(posedge clk_sys) disable iff (!rstN) // RULE2
        measEnd |=> thermSelect == $past(thermSelect) + 3'h1)
        else $error("thermistor index did not advance");

    chk_scan_interval: assert property (@(posedge clk_sys) disable iff (!rstN) // RULE1
        (state_reg == SCAN_HOLD && scanElapsed_reg < scanInt_reg) |=> state_reg == SCAN_HOLD)
        else $error("scan started early");

    chk_watchdog_trip: assert property (@(posedge clk_sys) disable iff (!rstN) // RULE6
        (wdCount_reg >= wdLimit_reg) |=> scanFault)
        else $error("watchdog did not trip");

    chk_filter_gate: assert property (@(posedge clk_sys) disable iff (!rstN) // RULE9
        (ratioValid && filter_reg[0] && !wireStart) |=> $stable(flag_reg))
        else $error("detection with 26 Hz filter");

    chk_count_ceiling: assert property (@(posedge clk_sys) disable iff (!rstN) // RULE13
        (hit && hitCount[ratioChannel] >= wCeil_reg[7:0] && $stable(wCeil_reg))
        |=> hitCount[$past(ratioChannel)] == $past(hitCount[ratioChannel]))
        else $error("counter passed ceiling");

    chk_flag_thresh: assert property (@(posedge clk_sys) disable iff (!rstN) // RULE12
        (hit && {24'h0, hitCount[ratioChannel]} + 32'h1 >= wThresh_reg)
        |=> flag_reg[$past(ratioChannel)])
        else $error("flag not set at threshold");

    chk_disable_flags: assert property (@(posedge clk_sys) disable iff (!rstN) // RULE16
        wDisable_reg[0] |-> openWireFlags == '0)
        else $error("open-wire reported while disabled");

    chk_equal_ok: assert property (@(posedge clk_sys) disable iff (!rstN) // RULE23
        (accept && ({22'h0, ratioValue} == rLow_reg || {22'h0, ratioValue} == rHigh_reg)) |-> !hit)
        else $error("limit value counted as error");

    chk_check_start: assert property (@(posedge clk_sys) disable iff (!rstN) // RULE10
        (wireStart && !periodHit && !(lockout_reg && !lockoutActive))
        |=> wireCheckActive && scansLeft_reg != 8'h00 && !pending_reg)
        else $error("open-wire check did not start");
endmodule

// File: bench/link_partner.sv
// Behavioural model of the cell monitoring modules on the module chain link.
`timescale 1ns/1ps
module link_partner (
    // Bench control
    input wire logic clk_sys,
    input wire logic [4:0] respDelay,
    input wire logic [cell_scan_pkg::CH_W-1:0] faultCh,
    input wire logic [9:0] faultRatio,
    // Link toward the monitor
    input wire logic measStart,
    output logic measDone,
    output logic ratioValid,
    output logic [cell_scan_pkg::CH_W-1:0] ratioChannel,
    output logic [9:0] ratioValue
);
    import cell_scan_pkg::*;
    int cnt;

    initial begin
        cnt = 0;
        measDone = 1'b0;
        ratioValid = 1'b0;
        ratioChannel = '0;
        ratioValue = '0;
    end

    // Outside a valid cycle the result lines toggle, so a stale value never looks like data.
    always @(posedge clk_sys) begin
        measDone <= 1'b0;
        ratioValid <= 1'b0;
        ratioChannel <= ~ratioChannel;
        ratioValue <= ~ratioValue;
        if (measStart === 1'b1) begin
            cnt <= int'(respDelay) + 1;
            ratioValid <= 1'b1;
            ratioChannel <= faultCh;
            ratioValue <= faultRatio;
        end else if (cnt == 1) begin
            measDone <= 1'b1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the cell scan monitor.
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_top;
    import cell_scan_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic we_i = 1'b0;
    logic [3:0] sel_i = 4'h0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic lockoutActive = 1'b0;
    logic dcBusConnected = 1'b0;
    logic [CH_W-1:0] faultCh = 5'h03;
    logic [9:0] faultRatio = 10'h31F;
    logic [4:0] respDelay = 5'h02;
    logic [31:0] dat_o, rd;
    logic ack_o, measStart, measDone, balanceAllow, filterSelect, wireCheckActive;
    logic linkPowerSupply, ratioValid, scanFault;
    logic [THERM_W-1:0] thermSelect, thermPrev;
    logic [1:0] linkPowerMode;
    logic [CH_W-1:0] ratioChannel;
    logic [9:0] ratioValue;
    logic [NUM_CH-1:0] openWireFlags;
    logic thermPend = 1'b0;
    int mismatches = 0;
    int samples_checked = 0;
    logic [31:0] rstTab [13] = '{RST_VARIANT, RST_MODCOUNT, RST_POWERMODE, RST_SCANINT,
        RST_SETTLE, RST_FILTER, RST_WDISABLE, RST_WINTERVAL, RST_WTHRESH, RST_WCEIL,
        RST_RLOW, RST_RHIGH, RST_WDLIMIT};
    logic [9:0] ratios [5] = '{10'h320, 10'h3CA, 10'h3CB, 10'h000, 10'h3E8};
    logic [4:0] fltBits = 5'h08;
    logic [4:0] expBits = 5'h14;

    cell_scan_open_wire_monitor uut (.clk_sys(clk_sys), .rst_b(rst_b), .adr_i(adr_i),
        .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .ack_o(ack_o), .measStart(measStart), .measDone(measDone), .thermSelect(thermSelect),
        .balanceAllow(balanceAllow), .filterSelect(filterSelect),
        .wireCheckActive(wireCheckActive), .linkPowerSupply(linkPowerSupply),
        .linkPowerMode(linkPowerMode), .ratioValid(ratioValid), .ratioChannel(ratioChannel),
        .ratioValue(ratioValue), .lockoutActive(lockoutActive),
        .dcBusConnected(dcBusConnected), .scanFault(scanFault), .openWireFlags(openWireFlags));

    link_partner farSide (.clk_sys(clk_sys), .respDelay(respDelay), .faultCh(faultCh),
        .faultRatio(faultRatio), .measStart(measStart), .measDone(measDone),
        .ratioValid(ratioValid), .ratioChannel(ratioChannel), .ratioValue(ratioValue));

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'hF;
        adr_i <= a;
        dat_i <= d;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            if (ack_o === 1'b1) begin
                rd = dat_o;
                cyc_i <= 1'b0;
                stb_i <= 1'b0;
                return;
            end
        end
        mismatches++;
        close_out();
    endtask

    task automatic wait_sig(input logic useFault, input logic lvl);
        for (int i = 0; i < 8000; i++) begin
            @(posedge clk_sys);
            if ((useFault ? scanFault : wireCheckActive) === lvl) begin
                return;
            end
        end
        mismatches++;
        close_out();
    endtask

    // Each finished measurement must step the thermistor and balancing must be off at a start.
    always @(posedge clk_sys) begin
        if (thermPend) begin
            `CHK(thermSelect, 3'(thermPrev + 3'h1));
        end
        thermPend = (measDone === 1'b1);
        thermPrev = thermSelect;
        if (measStart === 1'b1) begin
            `CHK(balanceAllow, 1'b0);
        end
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 13; i++) begin
            wb(1'b0, 8'(i * 4), 32'h0);
            `CHK(rd, rstTab[i]);
        end
        `CHK(linkPowerMode, POWER_MODE_NONE);
        `CHK(linkPowerSupply, 1'b0);
        wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        wb(1'b0, 8'h3C, 32'h0);
        `CHK(rd, 32'h0);
        wb(1'b1, ADDR_VARIANT, 32'h0);
        wb(1'b1, ADDR_MODCOUNT, 32'h1);
        wb(1'b1, ADDR_WCEIL, 32'h4);
        wb(1'b1, ADDR_FILTER, 32'h0);
        wb(1'b1, ADDR_SCANINT, 32'h5);
        `CHK(filterSelect, 1'b0);
        wb(1'b1, ADDR_SETTLE, 32'h2);
        wait_sig(1'b0, 1'b1);
        wait_sig(1'b0, 1'b0);
        repeat (2) @(posedge clk_sys);
        wb(1'b0, ADDR_FLAGS, 32'h0);
        `CHK(rd, 32'h8);
        wb(1'b1, ADDR_FLAGS, 32'h0);
        wb(1'b1, ADDR_WDISABLE, 32'h1);
        `CHK(openWireFlags, 32'h0);
        wb(1'b1, ADDR_WDISABLE, 32'h0);
        `CHK(openWireFlags, 32'h8);
        faultCh <= 5'h05;
        // Limit equality, both window edges, a slow far side and the wrong filter setting.
        for (int i = 0; i < 5; i++) begin
            faultRatio <= ratios[i];
            respDelay <= 5'(i * 6);
            wb(1'b1, ADDR_FILTER, 32'(fltBits[i]));
            lockoutActive <= 1'b1;
            repeat (2) @(posedge clk_sys);
            lockoutActive <= 1'b0;
            wait_sig(1'b0, 1'b1);
            wait_sig(1'b0, 1'b0);
            repeat (2) @(posedge clk_sys);
            `CHK(openWireFlags, expBits[i] ? 32'h20 : 32'h0);
        end
        // A periodic check only runs while the pack sits on the bus.
        wb(1'b1, ADDR_WINTERVAL, 32'h32);
        dcBusConnected <= 1'b1;
        wait_sig(1'b0, 1'b1);
        wait_sig(1'b0, 1'b0);
        dcBusConnected <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK(openWireFlags, 32'h20);
        wb(1'b1, ADDR_FILTER, 32'h1);
        wb(1'b1, ADDR_WDLIMIT, 32'h3);
        wait_sig(1'b1, 1'b1);
        wb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd[ST_FAULT_BIT], 1'b1);
        wb(1'b1, ADDR_WDLIMIT, 32'h64);
        wb(1'b1, ADDR_STATUS, 32'h1);
        wb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd[ST_FAULT_BIT], 1'b0);
        close_out();
    end
endmodule
